// File: rtl/qec_decode.sv
// Two-phase decoder: turns phase edges into one count step with a direction
`timescale 1ns/1ps

module qec_decode (
    input wire logic in_rise,
    input wire logic in_fall,
    input wire logic out_rise,
    input wire logic out_fall,
    input wire logic out_high,
    input wire logic x4,
    input wire logic dir_now,
    output logic step,
    output logic up,
    output logic dir_next
);

    always_comb begin
        dir_next = dir_now;
        step = 1'b0;
        up = 1'b0;
        if (x4) begin
            // Direction is fixed by the input phase moving while the output phase is high
            if ((in_rise | in_fall) && out_high) begin
                dir_next = in_rise; // [RULE_14] [RULE_15]
            end
            step = in_rise | in_fall | out_rise | out_fall; // [RULE_14] [RULE_15]
            up = dir_next;
        end else begin
            step = (in_rise | in_fall) & out_high; // [RULE_13]
            up = in_rise;
            if (step) begin
                dir_next = in_rise;
            end
        end
    end

endmodule // qec_decode

// File: rtl/qec_params.svh
// Constants of the quadrature event counter: offsets, field positions, reset values
`ifndef QEC_PARAMS_SVH
`define QEC_PARAMS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define QEC_NCH 3
`define QEC_CNT_W 16
`define QEC_ADDR_W 8
`define QEC_SYNC_W 7
// Channel index of the middle channel (the one with selectable decoding and Z-phase)
`define QEC_CH_MID 1

// ------------------------------------------------------------
// Register byte offsets (channel n at base + 4*n)
// ------------------------------------------------------------
`define QEC_OFF_START 8'h00
`define QEC_OFF_ZCTRL 8'h04
`define QEC_OFF_DIR 8'h08
`define QEC_OFF_MODE0 8'h10
`define QEC_OFF_CNT0 8'h20

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define QEC_BIT_PSR 8
`define QEC_BIT_FREE 6
`define QEC_BIT_DTYPE 7
`define QEC_BIT_ZEN 0
`define QEC_BIT_ZPOL 1
`define QEC_BIT_ZPEND 2

// ------------------------------------------------------------
// Counter values and reset values
// ------------------------------------------------------------
`define QEC_CNT_MAX 16'hFFFF
`define QEC_CNT_ZERO 16'h0000
`define QEC_RST_CNT 16'h0000
`define QEC_RST_ZPOL 1'h1

`endif

// File: rtl/qec_pkg.sv
// Types shared by the quadrature event counter modules
`include "qec_params.svh"

package qec_pkg;

    typedef logic [`QEC_CNT_W-1:0] qec_word_t;
    typedef logic [`QEC_ADDR_W-1:0] qec_addr_t;

    // Complete state of the counter core
    typedef struct packed {
        logic [`QEC_NCH-1:0] run;
        logic [`QEC_NCH-1:0] free;
        logic dtype;
        logic zen;
        logic zpol;
        logic zpend;
        logic [`QEC_NCH-1:0] dir;
        logic [`QEC_NCH-1:0] irq;
        logic [`QEC_NCH-1:0][`QEC_CNT_W-1:0] reload;
        logic [`QEC_NCH-1:0][`QEC_CNT_W-1:0] cnt;
        logic [31:0] prdata;
        logic pslverr;
    } qec_core_t;

    // State of the input synchroniser
    typedef struct packed {
        logic [`QEC_SYNC_W-1:0] meta;
        logic [`QEC_SYNC_W-1:0] sync;
        logic [`QEC_SYNC_W-1:0] prev;
    } qec_sync_t;

endpackage

// File: rtl/qec_sync.sv
// Two-flop synchroniser with edge detection for the phase and Z-phase pins
`timescale 1ns/1ps
`include "qec_params.svh"

module qec_sync #(
    parameter int W = `QEC_SYNC_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    import qec_pkg::*;

    if (W != `QEC_SYNC_W) begin : g_bad_width
        $error("qec_sync: W must match the synchroniser state width");
    end

    qec_sync_t q;
    qec_sync_t d;

    // ------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.meta = din;
        d.sync = q.meta;
        d.prev = q.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Edges come from comparing the two settled samples only
    assign level = q.sync;
    assign rise = q.sync & ~q.prev;
    assign fall = ~q.sync & q.prev;

endmodule // qec_sync

// File: rtl/qec_top.sv
// Quadrature event counter for channels two to four, with an APB register port
//
// Notes on behaviour
// RULE_01 - Only three channels exist, numbered two to four; no other channel has this mode.
// RULE_02 - Counts come only from the phase input and phase output pins, both inputs.
// RULE_03 - Reload type loads the reload value on overflow or underflow; pins set direction.
// RULE_04 - Free-run type wraps past overflow or underflow without loading the reload value.
// RULE_05 - Reload period is FFFFh-n+1 events counting up and n+1 counting down.
// RULE_06 - The run bit starts counting at 1 and stops it at 0.
// RULE_07 - Each overflow or underflow raises the channel interrupt request.
// RULE_08 - Reading the counter register returns the live count.
// RULE_09 - Writing the counter while stopped loads reload register and counter.
// RULE_10 - Writing the counter while running loads only the reload register.
// RULE_11 - Decode type bit b7 of the mode register acts on channel three only.
// RULE_12 - Channel two always decodes normally, channel four always multiply-by-4.
// RULE_13 - Normal: up on input rise, down on input fall, only while output is high.
// RULE_14 - x4: input rising while output high makes every edge of both count up.
// RULE_15 - x4: input falling while output high makes every edge of both count down.
// RULE_16 - Channel three can clear its count to zero on an accepted Z-phase edge.
// RULE_17 - Software sets the Z-phase enable bit only when Z-phase clearing is used.
// RULE_18 - Software writes 1 to the prescaler reset bit during setup.
// RULE_19 - Z-phase clearing needs channel three, free-run, x4 and the Z-phase pin.
// RULE_20 - An accepted Z-phase edge clears the counter at the next count step.
// RULE_21 - A polarity bit picks the rising or falling Z-phase edge.
// RULE_22 - Software writes 0000h to channel three counter before enabling Z-phase.
// RULE_23 - All pins are synchronised and edges found from registered samples.
// RULE_24 - Sixteen-bit counter wraps both ways and moves at most one step per cycle.
`timescale 1ns/1ps
`include "qec_params.svh"

module qec_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire qec_pkg::qec_addr_t paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`QEC_NCH-1:0] phase_in_pin,
    input wire logic [`QEC_NCH-1:0] phase_out_pin,
    input wire logic zphase_pin,
    output logic [`QEC_NCH-1:0] count_irq
);
    import qec_pkg::*;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    // One-hot channel hit for a register bank starting at base
    function automatic logic [`QEC_NCH-1:0] bank_hit(input qec_addr_t a, input qec_addr_t base);
        logic [`QEC_NCH-1:0] h;
        h = '0;
        for (int k = 0; k < `QEC_NCH; k++) begin
            h[k] = (a == base + qec_addr_t'(4 * k));
        end
        return h;
    endfunction

    // Decoding style of a channel: fixed on the outer two, selectable on the middle one
    function automatic logic chan_x4(input int ch, input logic dtype);
        logic r;
        r = 1'b0;
        if (ch == `QEC_CH_MID) begin
            r = dtype; // [RULE_11]
        end else if (ch > `QEC_CH_MID) begin
            r = 1'b1; // [RULE_12]
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation and decoding
    // ------------------------------------------------------------
    logic [`QEC_SYNC_W-1:0] pin_raw;
    logic [`QEC_SYNC_W-1:0] pin_lvl;
    logic [`QEC_SYNC_W-1:0] pin_rise;
    logic [`QEC_SYNC_W-1:0] pin_fall;
    logic [`QEC_NCH-1:0] step;
    logic [`QEC_NCH-1:0] step_up;
    logic [`QEC_NCH-1:0] dir_next;
    logic z_edge;

    qec_core_t q;
    qec_core_t d;

    // Both phase pins are inputs only in this mode
    assign pin_raw = {zphase_pin, phase_out_pin, phase_in_pin}; // [RULE_02]

    qec_sync #(
        .W(`QEC_SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    ); // [RULE_23]

    for (genvar g = 0; g < `QEC_NCH; g++) begin : g_dec
        qec_decode u_dec (
            .in_rise(pin_rise[g]),
            .in_fall(pin_fall[g]),
            .out_rise(pin_rise[`QEC_NCH + g]),
            .out_fall(pin_fall[`QEC_NCH + g]),
            .out_high(pin_lvl[`QEC_NCH + g]),
            .x4(chan_x4(g, q.dtype)),
            .dir_now(q.dir[g]),
            .step(step[g]),
            .up(step_up[g]),
            .dir_next(dir_next[g])
        );
    end

    // Z-phase edge of the chosen polarity
    assign z_edge = q.zpol ? pin_rise[2 * `QEC_NCH] : pin_fall[2 * `QEC_NCH]; // [RULE_21]

    // ------------------------------------------------------------
    // Register file and counters
    // ------------------------------------------------------------
    logic [`QEC_NCH-1:0] mode_hit;
    logic [`QEC_NCH-1:0] cnt_hit;
    logic hit_start;
    logic hit_zctrl;
    logic hit_dir;
    logic acc_wr;
    logic z_armed;

    assign mode_hit = bank_hit(paddr, `QEC_OFF_MODE0);
    assign cnt_hit = bank_hit(paddr, `QEC_OFF_CNT0); // [RULE_01]
    assign hit_start = (paddr == `QEC_OFF_START);
    assign hit_zctrl = (paddr == `QEC_OFF_ZCTRL);
    assign hit_dir = (paddr == `QEC_OFF_DIR);
    assign acc_wr = psel & penable & pwrite;

    // Clearing by Z-phase only in its one legal configuration
    assign z_armed = q.zen & q.free[`QEC_CH_MID] & q.dtype; // [RULE_19]

    always_comb begin
        d = q;
        d.irq = '0;

        // Counting, one step per cycle at most
        for (int i = 0; i < `QEC_NCH; i++) begin
            if (q.run[i]) begin // [RULE_06]
                d.dir[i] = dir_next[i];
                if (step[i]) begin // [RULE_24]
                    if (i == `QEC_CH_MID && z_armed && q.zpend) begin
                        d.cnt[i] = `QEC_CNT_ZERO; // [RULE_16] [RULE_20]
                    end else if (step_up[i]) begin
                        if (q.cnt[i] == `QEC_CNT_MAX) begin
                            d.irq[i] = 1'b1; // [RULE_07]
                            // Reload gives FFFFh-n+1 events per period upward
                            d.cnt[i] = q.free[i] ? `QEC_CNT_ZERO : q.reload[i]; // [RULE_03] [RULE_04] [RULE_05]
                        end else begin
                            d.cnt[i] = q.cnt[i] + `QEC_CNT_W'(1); // [RULE_24]
                        end
                    end else begin
                        if (q.cnt[i] == `QEC_CNT_ZERO) begin
                            d.irq[i] = 1'b1; // [RULE_07]
                            // Reload gives n+1 events per period downward
                            d.cnt[i] = q.free[i] ? `QEC_CNT_MAX : q.reload[i]; // [RULE_03] [RULE_04] [RULE_05]
                        end else begin
                            d.cnt[i] = q.cnt[i] - `QEC_CNT_W'(1); // [RULE_24]
                        end
                    end
                end
            end
        end

        // Z-phase pending: a new edge wins over the clear made by this step
        if (!z_armed) begin
            d.zpend = 1'b0;
        end else if (z_edge) begin
            d.zpend = 1'b1; // [RULE_20]
        end else if (q.run[`QEC_CH_MID] && step[`QEC_CH_MID]) begin
            d.zpend = 1'b0;
        end

        // Read data and error are captured in the setup cycle
        if (psel && !penable) begin
            d.prdata = '0;
            d.pslverr = 1'b0;
            if (hit_start) begin
                d.prdata[`QEC_NCH-1:0] = q.run;
            end else if (hit_zctrl) begin
                d.prdata[`QEC_BIT_ZEN] = q.zen;
                d.prdata[`QEC_BIT_ZPOL] = q.zpol;
                d.prdata[`QEC_BIT_ZPEND] = q.zpend;
            end else if (hit_dir) begin
                d.prdata[`QEC_NCH-1:0] = q.dir;
            end else if (|mode_hit) begin
                for (int i = 0; i < `QEC_NCH; i++) begin
                    if (mode_hit[i]) begin
                        d.prdata[`QEC_BIT_FREE] = q.free[i];
                        d.prdata[`QEC_BIT_DTYPE] = (i == `QEC_CH_MID) ? q.dtype : 1'b0;
                    end
                end
            end else if (|cnt_hit) begin
                for (int i = 0; i < `QEC_NCH; i++) begin
                    if (cnt_hit[i]) begin
                        d.prdata[`QEC_CNT_W-1:0] = q.cnt[i]; // [RULE_08]
                    end
                end
            end else begin
                d.pslverr = 1'b1;
            end
        end

        // Writes take effect in the access cycle
        if (acc_wr) begin
            if (hit_start) begin
                // Prescaler reset bit is accepted and reads back as zero
                d.run = pwdata[`QEC_NCH-1:0]; // [RULE_06]
            end else if (hit_zctrl) begin
                d.zen = pwdata[`QEC_BIT_ZEN];
                d.zpol = pwdata[`QEC_BIT_ZPOL];
            end
            for (int i = 0; i < `QEC_NCH; i++) begin
                if (mode_hit[i]) begin
                    d.free[i] = pwdata[`QEC_BIT_FREE];
                    if (i == `QEC_CH_MID) begin
                        d.dtype = pwdata[`QEC_BIT_DTYPE]; // [RULE_11]
                    end
                end
                if (cnt_hit[i]) begin
                    d.reload[i] = pwdata[`QEC_CNT_W-1:0]; // [RULE_10]
                    if (!q.run[i]) begin
                        d.cnt[i] = pwdata[`QEC_CNT_W-1:0]; // [RULE_09]
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.zpol <= `QEC_RST_ZPOL;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr & psel & penable;
    assign count_irq = q.irq; // [RULE_07]

endmodule // qec_top

// File: verification/qec_assertions.sv
// Port-level checker for the quadrature event counter
`timescale 1ns/1ps
`include "qec_params.svh"

module qec_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire qec_pkg::qec_addr_t paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`QEC_NCH-1:0] phase_in_pin,
    input wire logic [`QEC_NCH-1:0] phase_out_pin,
    input wire logic zphase_pin,
    input wire logic [`QEC_NCH-1:0] count_irq
);
    import qec_pkg::*;
    logic [`QEC_NCH-1:0] run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= '0;
        end else if (psel && penable && pwrite && paddr == `QEC_OFF_START) begin
            run_q <= pwdata[`QEC_NCH-1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_read;
        psel && penable && !pwrite;
    endsequence
    sequence s_quiet;
        ($stable(phase_in_pin) && $stable(phase_out_pin))[*8];
    endsequence
    property p_irq_run;
        count_irq != '0 |-> (count_irq & ~(run_q | $past(run_q) | $past(run_q, 2))) == '0;
    endproperty
    a_irq_run: assert property (p_irq_run) else $error("irq on stopped channel");
    property p_irq_pins;
        s_quiet |=> count_irq == '0;
    endproperty
    a_irq_pins: assert property (p_irq_pins) else $error("irq without pin edges");
    property p_err_unmapped;
        psel && penable && (paddr == 8'h1C || paddr == 8'h2C) |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase) else $error("stray error");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_cnt_upper;
        s_read ##0 (paddr >= `QEC_OFF_CNT0) |-> prdata[31:16] == 16'h0000;
    endproperty
    a_cnt_upper: assert property (p_cnt_upper) else $error("count too wide");
    property p_mode_dtype;
        s_read ##0 (paddr == `QEC_OFF_MODE0 || paddr == 8'h18) |-> !prdata[`QEC_BIT_DTYPE];
    endproperty
    a_mode_dtype: assert property (p_mode_dtype) else $error("decode bit kept");
    property p_run_read;
        s_read ##0 paddr == `QEC_OFF_START |-> prdata[2:0] == run_q && !prdata[`QEC_BIT_PSR];
    endproperty
    a_run_read: assert property (p_run_read) else $error("run bits differ");
endmodule // qec_chk

bind qec_top qec_chk qec_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_in_pin(phase_in_pin), .phase_out_pin(phase_out_pin), .zphase_pin(zphase_pin),
    .count_irq(count_irq)
);

// File: verification/qec_encoder.sv
// Two-phase pulse source with a Z-phase line, standing in for a rotary encoder
`timescale 1ns/1ps
`include "qec_params.svh"

module qec_encoder (
    input wire logic pclk,
    output logic [`QEC_NCH-1:0] phase_in_pin,
    output logic [`QEC_NCH-1:0] phase_out_pin,
    output logic zphase_pin
);
    initial begin
        phase_in_pin = '0;
        phase_out_pin = '0;
        zphase_pin = 1'b0;
    end
    // Forward walks {in,out} 01-11-10-00, backward 10-11-01-00
    task automatic turn(input int ch, input bit up, input int n, input int hold);
        logic [7:0] pat;
        pat = up ? 8'h78 : 8'hB4;
        repeat (n) begin
            for (int k = 3; k >= 0; k--) begin
                {phase_in_pin[ch], phase_out_pin[ch]} <= pat[2*k +: 2];
                repeat (hold) @(posedge pclk);
            end
        end
    endtask
    task automatic zset(input logic lvl);
        zphase_pin <= lvl;
        repeat (3) @(posedge pclk);
    endtask
endmodule // qec_encoder

// File: verification/tb_top.sv
// Self-checking bench for the quadrature event counter
`timescale 1ns/1ps
`include "qec_params.svh"

module tb_top;
    import qec_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    qec_addr_t paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [`QEC_NCH-1:0] phase_in_pin;
    logic [`QEC_NCH-1:0] phase_out_pin;
    logic zphase_pin;
    logic [`QEC_NCH-1:0] count_irq;
    int miscompares = 0;
    int compares = 0;
    int irqs = 0;
    int cycles = 0;

    always #4 pclk = ~pclk;
    // Pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge pclk) irqs += int'($countones(count_irq));

    qec_top qec_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_in_pin(phase_in_pin), .phase_out_pin(phase_out_pin),
        .zphase_pin(zphase_pin), .count_irq(count_irq));
    qec_encoder qec_encoder_inst (.pclk(pclk), .phase_in_pin(phase_in_pin),
        .phase_out_pin(phase_out_pin), .zphase_pin(zphase_pin));

    task automatic end_sim;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic apb(input bit w, input qec_addr_t a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input qec_addr_t a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input qec_addr_t a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input qec_addr_t a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        chk(r, exp);
    endtask
    function automatic qec_addr_t ca(input int ch);
        return `QEC_OFF_CNT0 + 8'(ch * 4);
    endfunction
    function automatic qec_addr_t ma(input int ch);
        return `QEC_OFF_MODE0 + 8'(ch * 4);
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Turns the encoder, then waits out the pin synchroniser
    task automatic spin(input int ch, input bit up, input int n);
        qec_encoder_inst.turn(ch, up, n, 2);
        wt(6);
    endtask

    task automatic t_normal;
        wr(ma(0), 32'h80);
        chk_rd(ma(0), 32'h0);
        wr(ca(0), 32'h10);
        chk_rd(ca(0), 32'h10);
        wr(`QEC_OFF_START, 32'h1);
        spin(0, 1'b1, 3);
        chk_rd(ca(0), 32'h13);
        chk_rd(`QEC_OFF_DIR, 32'h1);
        qec_encoder_inst.turn(0, 1'b0, 1, 5);
        wt(6);
        chk_rd(ca(0), 32'h12);
        wr(`QEC_OFF_START, 32'h0);
        spin(0, 1'b1, 2);
        chk_rd(ca(0), 32'h12);
    endtask
    task automatic t_reload;
        wr(ca(0), 32'hFFFD);
        wr(`QEC_OFF_START, 32'h1);
        irqs = 0;
        spin(0, 1'b1, 2);
        wr(ca(0), 32'hFFFB);
        chk_rd(ca(0), 32'hFFFF);
        spin(0, 1'b1, 1);
        chk_rd(ca(0), 32'hFFFB);
        spin(0, 1'b1, 4);
        chk_rd(ca(0), 32'hFFFF);
        spin(0, 1'b1, 1);
        chk_rd(ca(0), 32'hFFFB);
        wr(`QEC_OFF_START, 32'h0);
        wr(ca(0), 32'h2);
        wr(`QEC_OFF_START, 32'h1);
        spin(0, 1'b0, 2);
        chk_rd(ca(0), 32'h0);
        spin(0, 1'b0, 1);
        chk_rd(ca(0), 32'h2);
        chk(irqs, 32'h3);
    endtask
    task automatic t_free;
        wr(`QEC_OFF_START, 32'h0);
        wr(ma(0), 32'h40);
        wr(ca(0), 32'hFFFE);
        wr(`QEC_OFF_START, 32'h1);
        irqs = 0;
        spin(0, 1'b1, 2);
        chk_rd(ca(0), 32'h0);
        spin(0, 1'b0, 2);
        chk_rd(ca(0), 32'hFFFE);
        chk(irqs, 32'h2);
    endtask
    task automatic t_x4;
        logic [31:0] b;
        wr(`QEC_OFF_START, 32'h6);
        for (int ch = 1; ch < 3; ch++) begin
            wr(ma(ch), 32'h80);
            chk_rd(ma(ch), ch == 1 ? 32'h80 : 32'h0);
            spin(ch, 1'b1, 1);
            rd(ca(ch), b);
            spin(ch, 1'b1, 2);
            chk_rd(ca(ch), b + 32'h8);
            spin(ch, 1'b0, 1);
            rd(ca(ch), b);
            spin(ch, 1'b0, 1);
            chk_rd(ca(ch), b - 32'h4);
        end
        wr(ma(1), 32'h0);
        rd(ca(1), b);
        spin(1, 1'b1, 1);
        chk_rd(ca(1), b + 32'h1);
    endtask
    task automatic t_zphase;
        logic [31:0] c;
        wr(`QEC_OFF_START, 32'h0);
        wr(ma(1), 32'hC0);
        wr(ca(1), 32'h0);
        wr(`QEC_OFF_ZCTRL, 32'h3);
        wr(`QEC_OFF_START, 32'h2);
        spin(1, 1'b1, 1);
        rd(ca(1), c);
        qec_encoder_inst.zset(1'b1);
        wt(6);
        chk_rd(`QEC_OFF_ZCTRL, 32'h7);
        chk_rd(ca(1), c);
        spin(1, 1'b1, 1);
        chk_rd(ca(1), 32'h3);
        qec_encoder_inst.zset(1'b0);
        spin(1, 1'b1, 1);
        chk_rd(ca(1), 32'h7);
        wr(`QEC_OFF_ZCTRL, 32'h1);
        qec_encoder_inst.zset(1'b1);
        spin(1, 1'b1, 1);
        chk_rd(ca(1), 32'hB);
        qec_encoder_inst.zset(1'b0);
        spin(1, 1'b1, 1);
        chk_rd(ca(1), 32'h3);
    endtask
    task automatic t_err;
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h1C, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h2C, 32'hFFFF, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wt(2);
        wr(`QEC_OFF_START, 32'h100);
        chk_rd(`QEC_OFF_START, 32'h0);
        t_normal();
        t_reload();
        t_free();
        t_x4();
        t_zphase();
        t_err();
        end_sim();
    end
endmodule // tb_top
